// *** rtl/pdcr_pkg.sv ***
// constants and carrier types for the power-down control register bank
//
// Overview of operation
// - Bit 5 of power_down_global_control selects the power-down mask: zero picks mask one, one picks mask two.
// - Mask one is the pair of registers 20h and 21h.
// - Mask two is the pair of registers 23h and 24h.
// - The selected mask only acts while the register sleep enable bit in register 55h is set.
// - A two-bit buffer field of 00 keeps both buffers of a channel on and 11 powers both off; software never writes 01 or 10.
// - Bit 7 of 26h set puts the device into global sleep under register control; clear means normal operation.
// - With the override bit set the power-down pin level is ignored; clear means normal operation.
// - Bit 0 of 4Fh set enables dc-coupling support on the analog inputs; clear disables it.
// - With the register sleep enable set, exactly the blocks named in the selected mask are powered down.
// - A core mask value of 0Fh powers down channel B, F0h channel A, FFh both.
// - Bit 6 of the sysref control register set makes the device ignore the sysref input.
package pdcr_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    localparam logic [7:0] ADDR_CORE_MASK_ONE = 8'h20;
    localparam logic [7:0] ADDR_BUF_MASK_ONE  = 8'h21;
    localparam logic [7:0] ADDR_CORE_MASK_TWO = 8'h23;
    localparam logic [7:0] ADDR_BUF_MASK_TWO  = 8'h24;
    localparam logic [7:0] ADDR_GLOBAL_CTRL   = 8'h26;
    localparam logic [7:0] ADDR_PERF_LOW      = 8'h39;
    localparam logic [7:0] ADDR_PERF_MID      = 8'h3A;
    localparam logic [7:0] ADDR_COUPLING      = 8'h4F;
    localparam logic [7:0] ADDR_SYSREF_CTRL   = 8'h53;
    localparam logic [7:0] ADDR_SLEEP_ENABLE  = 8'h55;
    localparam logic [7:0] ADDR_PERF_HIGH     = 8'h56;

    // writable bits per register; the rest are reserved and read zero
    localparam logic [7:0] WMASK_CORE    = 8'hFF;
    localparam logic [7:0] WMASK_BUF     = 8'hF0;
    localparam logic [7:0] WMASK_GLOBAL  = 8'hE0;
    localparam logic [7:0] WMASK_PERF_LO = 8'hC0;
    localparam logic [7:0] WMASK_PERF_MI = 8'h40;
    localparam logic [7:0] WMASK_COUPLE  = 8'h01;
    localparam logic [7:0] WMASK_SYSREF  = 8'h43;
    localparam logic [7:0] WMASK_SLEEP   = 8'h10;
    localparam logic [7:0] WMASK_PERF_HI = 8'h04;
    localparam logic [7:0] REG_RESET     = 8'h00;

    localparam int BIT_GLOBAL_SLEEP  = 7;
    localparam int BIT_PIN_OVERRIDE  = 6;
    localparam int BIT_MASK_SELECT   = 5;
    localparam int BIT_SLEEP_ENABLE  = 4;
    localparam int BIT_PERF_LOW_HI   = 7;
    localparam int BIT_PERF_LOW_LO   = 6;
    localparam int BIT_PERF_MID      = 6;
    localparam int BIT_PERF_HIGH     = 2;
    localparam int BIT_DC_COUPLING   = 0;
    localparam int BIT_SYSREF_IGNORE = 6;
    localparam int BIT_SYSREF_HICM   = 1;
    localparam int BIT_SYSREF_LEVEL  = 0;
    localparam int CORE_A_HI = 7;
    localparam int CORE_A_LO = 4;
    localparam int CORE_B_HI = 3;
    localparam int CORE_B_LO = 0;
    localparam int BUF_B_HI  = 7;
    localparam int BUF_B_LO  = 6;
    localparam int BUF_A_HI  = 5;
    localparam int BUF_A_LO  = 4;

    localparam logic [3:0] CORE_ALL_OFF = 4'hF;
    localparam logic [1:0] BUF_BOTH_OFF = 2'h3;

    typedef struct packed {
        logic [7:0] core_mask_one;
        logic [7:0] buf_mask_one;
        logic [7:0] core_mask_two;
        logic [7:0] buf_mask_two;
        logic [7:0] global_ctrl;
        logic [7:0] perf_low;
        logic [7:0] perf_mid;
        logic [7:0] coupling;
        logic [7:0] sysref_ctrl;
        logic [7:0] sleep_enable;
        logic [7:0] perf_high;
    } pdcr_regs_t;

    typedef struct packed {
        logic       chan_a_core_powerdown;
        logic       chan_b_core_powerdown;
        logic       chan_a_buffer_powerdown;
        logic       chan_b_buffer_powerdown;
        logic       device_sleep;
        logic [3:0] performance_setting;
        logic       input_dc_coupling_enable;
        logic       sysref_ignore;
        logic       sysref_high_common_mode_enable;
        logic       sysref_manual_level;
    } pdcr_ctrl_t;

    typedef struct packed {
        pdcr_regs_t       regs;
        pdcr_ctrl_t       ctrl;
        logic [7:0]       rdata;
    } pdcr_state_t;

endpackage : pdcr_pkg

// *** rtl/pdcr_bank.sv ***
// power-down control register bank with derived control outputs
`timescale 1ns/1ns
module pdcr_bank
    import pdcr_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              reg_wr_i,
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic [DATA_W-1:0] reg_wdata_i,
    input  wire logic              sleep_pin_i,
    output logic      [DATA_W-1:0] reg_rdata_o,
    output pdcr_ctrl_t             ctrl_o
);

    pdcr_state_t state_ff;
    pdcr_state_t nxt_state;

    ////////////////////////////////////////////////////////////////////////
    // register writes, read mux and control decode

    always_comb
    begin
        logic [7:0] core_sel;
        logic [7:0] buf_sel;
        logic       mask_active;
        logic       sleep_now;
        pdcr_regs_t r;
        core_sel    = '0;
        buf_sel     = '0;
        mask_active = 1'b0;
        sleep_now   = 1'b0;
        r         = state_ff.regs;
        nxt_state = state_ff;
        if (reg_wr_i)
        begin
            // reserved bits never store
            case (reg_addr_i)
                ADDR_CORE_MASK_ONE: r.core_mask_one = reg_wdata_i & WMASK_CORE;
                ADDR_BUF_MASK_ONE:  r.buf_mask_one  = reg_wdata_i & WMASK_BUF;
                ADDR_CORE_MASK_TWO: r.core_mask_two = reg_wdata_i & WMASK_CORE;
                ADDR_BUF_MASK_TWO:  r.buf_mask_two  = reg_wdata_i & WMASK_BUF;
                ADDR_GLOBAL_CTRL:   r.global_ctrl   = reg_wdata_i & WMASK_GLOBAL;
                ADDR_PERF_LOW:      r.perf_low      = reg_wdata_i & WMASK_PERF_LO;
                ADDR_PERF_MID:      r.perf_mid      = reg_wdata_i & WMASK_PERF_MI;
                ADDR_COUPLING:      r.coupling      = reg_wdata_i & WMASK_COUPLE;
                ADDR_SYSREF_CTRL:   r.sysref_ctrl   = reg_wdata_i & WMASK_SYSREF;
                ADDR_SLEEP_ENABLE:  r.sleep_enable  = reg_wdata_i & WMASK_SLEEP;
                ADDR_PERF_HIGH:     r.perf_high     = reg_wdata_i & WMASK_PERF_HI;
                default:            r = state_ff.regs;
            endcase
        end
        nxt_state.regs = r;

        case (reg_addr_i)
            ADDR_CORE_MASK_ONE: nxt_state.rdata = r.core_mask_one;
            ADDR_BUF_MASK_ONE:  nxt_state.rdata = r.buf_mask_one;
            ADDR_CORE_MASK_TWO: nxt_state.rdata = r.core_mask_two;
            ADDR_BUF_MASK_TWO:  nxt_state.rdata = r.buf_mask_two;
            ADDR_GLOBAL_CTRL:   nxt_state.rdata = r.global_ctrl;
            ADDR_PERF_LOW:      nxt_state.rdata = r.perf_low;
            ADDR_PERF_MID:      nxt_state.rdata = r.perf_mid;
            ADDR_COUPLING:      nxt_state.rdata = r.coupling;
            ADDR_SYSREF_CTRL:   nxt_state.rdata = r.sysref_ctrl;
            ADDR_SLEEP_ENABLE:  nxt_state.rdata = r.sleep_enable;
            ADDR_PERF_HIGH:     nxt_state.rdata = r.perf_high;
            default:            nxt_state.rdata = REG_RESET;
        endcase

        // mask one or two by select bit
        if (r.global_ctrl[BIT_MASK_SELECT])
        begin
            core_sel = r.core_mask_two;
            buf_sel  = r.buf_mask_two;
        end
        else
        begin
            core_sel = r.core_mask_one;
            buf_sel  = r.buf_mask_one;
        end
        mask_active = r.sleep_enable[BIT_SLEEP_ENABLE];

        // pin unless overridden, then global bit
        if (r.global_ctrl[BIT_PIN_OVERRIDE])
            sleep_now = r.global_ctrl[BIT_GLOBAL_SLEEP];
        else
            sleep_now = sleep_pin_i;
        nxt_state.ctrl.device_sleep = sleep_now;

        // exactly the selected mask's blocks
        nxt_state.ctrl.chan_a_core_powerdown = mask_active
            && (core_sel[CORE_A_HI:CORE_A_LO] == CORE_ALL_OFF);
        nxt_state.ctrl.chan_b_core_powerdown = mask_active
            && (core_sel[CORE_B_HI:CORE_B_LO] == CORE_ALL_OFF);
        nxt_state.ctrl.chan_a_buffer_powerdown = mask_active
            && (buf_sel[BUF_A_HI:BUF_A_LO] == BUF_BOTH_OFF);
        nxt_state.ctrl.chan_b_buffer_powerdown = mask_active
            && (buf_sel[BUF_B_HI:BUF_B_LO] == BUF_BOTH_OFF);

        // split field reassembled
        nxt_state.ctrl.performance_setting = {r.perf_high[BIT_PERF_HIGH],
                                              r.perf_mid[BIT_PERF_MID],
                                              r.perf_low[BIT_PERF_LOW_HI],
                                              r.perf_low[BIT_PERF_LOW_LO]};
        nxt_state.ctrl.input_dc_coupling_enable =
            r.coupling[BIT_DC_COUPLING];
        nxt_state.ctrl.sysref_ignore =
            r.sysref_ctrl[BIT_SYSREF_IGNORE];
        nxt_state.ctrl.sysref_high_common_mode_enable =
            r.sysref_ctrl[BIT_SYSREF_HICM];
        nxt_state.ctrl.sysref_manual_level =
            r.sysref_ctrl[BIT_SYSREF_LEVEL];
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
            state_ff <= '0;
        else
            state_ff <= nxt_state;
    end

    assign reg_rdata_o = state_ff.rdata;
    assign ctrl_o      = state_ff.ctrl;

endmodule : pdcr_bank

// *** sim/pdcr_chk.sv ***
// assertions on the power-down control register bank ports
`timescale 1ns/1ns
module pdcr_chk
    import pdcr_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic              reg_wr_i,
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic [DATA_W-1:0] reg_wdata_i,
    input  wire logic              sleep_pin_i,
    input  wire logic [DATA_W-1:0] reg_rdata_o,
    input  wire pdcr_ctrl_t        ctrl_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    logic wr26;
    assign wr26 = reg_wr_i && reg_addr_i == ADDR_GLOBAL_CTRL;
    ////////////////////////////////////////////////////////////////////////
    a_sleep_source:
    assert property (wr26 |=> ctrl_o.device_sleep == ($past(reg_wdata_i[6])
        ? $past(reg_wdata_i[7]) : $past(sleep_pin_i))) else $error("sleep");
    a_coupling_bit:
    assert property (reg_wr_i && reg_addr_i == ADDR_COUPLING |=>
        ctrl_o.input_dc_coupling_enable == $past(reg_wdata_i[0]))
        else $error("dc coupling");
    a_sysref_ignore:
    assert property (reg_wr_i && reg_addr_i == ADDR_SYSREF_CTRL |=>
        ctrl_o.sysref_ignore == $past(reg_wdata_i[6])) else $error("sysref");
    a_perf_low:
    assert property (reg_wr_i && reg_addr_i == ADDR_PERF_LOW |=>
        ctrl_o.performance_setting[1:0] == $past(reg_wdata_i[7:6]))
        else $error("perf low");
    a_mask_gated:
    assert property (reg_wr_i && reg_addr_i == ADDR_SLEEP_ENABLE &&
        !reg_wdata_i[4] |=> !(ctrl_o.chan_a_core_powerdown ||
        ctrl_o.chan_b_core_powerdown || ctrl_o.chan_a_buffer_powerdown ||
        ctrl_o.chan_b_buffer_powerdown)) else $error("mask gate");
    a_reset_clear:
    assert property ($fell(sys_rst_i) |-> reg_rdata_o == REG_RESET &&
        ctrl_o == '0) else $error("reset values");
    a_reserved_zero:
    assert property (reg_addr_i == ADDR_GLOBAL_CTRL |=>
        reg_rdata_o[4:0] == 5'h00) else $error("reserved bits");
    a_mask_readback:
    assert property (reg_wr_i && reg_addr_i == ADDR_CORE_MASK_ONE |=>
        reg_rdata_o == $past(reg_wdata_i)) else $error("read back");
    c_global: cover property (wr26 && reg_wdata_i[7:6] == 2'h3);
    c_reset: cover property ($fell(sys_rst_i));
    c_core_b: cover property (ctrl_o.chan_b_core_powerdown);
endmodule : pdcr_chk
bind pdcr_bank pdcr_chk pdcr_chk_inst(.sys_clk_i, .sys_rst_i, .reg_wr_i,
    .reg_addr_i, .reg_wdata_i, .sleep_pin_i, .reg_rdata_o, .ctrl_o);

// *** sim/pdcr_bank_bench.sv ***
// self-checking bench for the power-down control register bank
`timescale 1ns/1ns
module pdcr_bank_bench
    import pdcr_pkg::*;
;
    logic       sys_clk_i   = 1'b0;
    logic       sys_rst_i   = 1'b1;
    logic       reg_wr_i    = 1'b0;
    logic [7:0] reg_addr_i  = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic       sleep_pin_i = 1'b0;
    logic [7:0] reg_rdata_o;
    pdcr_ctrl_t ctrl_o;
    int         fails       = 0;
    int         check_count = 0;
    logic [7:0] adr [11] = '{8'h20, 8'h21, 8'h23, 8'h24, 8'h26, 8'h39,
                             8'h3A, 8'h4F, 8'h53, 8'h55, 8'h56};
    logic [7:0] msk [11] = '{8'hFF, 8'hF0, 8'hFF, 8'hF0, 8'hE0, 8'hC0,
                             8'h40, 8'h01, 8'h43, 8'h10, 8'h04};
    pdcr_bank pdcr_bank_inst(.sys_clk_i, .sys_rst_i, .reg_wr_i, .reg_addr_i,
        .reg_wdata_i, .sleep_pin_i, .reg_rdata_o, .ctrl_o);
    initial forever #10 sys_clk_i = ~sys_clk_i;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] got, exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge sys_clk_i);
        reg_wr_i = 1'b0;
        @(negedge sys_clk_i);
    endtask : wr
    task automatic rd(input logic [7:0] a, exp);
        reg_addr_i = a;
        @(negedge sys_clk_i);
        chk("rdata", reg_rdata_o, exp);
    endtask : rd
    task automatic pdn(input logic [3:0] e);
        chk("pdn", {4'h0, ctrl_o.chan_a_core_powerdown,
            ctrl_o.chan_b_core_powerdown, ctrl_o.chan_a_buffer_powerdown,
            ctrl_o.chan_b_buffer_powerdown}, {4'h0, e});
    endtask : pdn
    task automatic slp(input logic p, e);
        sleep_pin_i = p;
        @(negedge sys_clk_i);
        chk("sleep", {7'h0, ctrl_o.device_sleep}, {7'h0, e});
    endtask : slp
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        for (int i = 0; i < 11; i++)
        begin
            rd(adr[i], 8'h00);
            if (adr[i] == 8'h26)
                wr(adr[i], 8'h40);
            wr(adr[i], 8'hFF);
            rd(adr[i], msk[i]);
        end
        wr(8'h30, 8'hFF);
        rd(8'h30, 8'h00);
        sys_rst_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        rd(8'h26, 8'h00);
        pdn(4'h0);
        slp(1'b1, 1'b1);
        wr(8'h26, 8'h40);
        slp(1'b1, 1'b0);
        wr(8'h26, 8'hC0);
        slp(1'b0, 1'b1);
        wr(8'h26, 8'h80);
        slp(1'b0, 1'b0);
        slp(1'b1, 1'b1);
        wr(8'h20, 8'hF0);
        wr(8'h21, 8'hC0);
        wr(8'h23, 8'h0F);
        wr(8'h24, 8'h30);
        wr(8'h55, 8'h00);
        pdn(4'h0);
        wr(8'h55, 8'h10);
        pdn(4'b1001);
        wr(8'h26, 8'h20);
        pdn(4'b0110);
        wr(8'h24, 8'h00);
        pdn(4'b0100);
        wr(8'h23, 8'hFF);
        pdn(4'b1100);
        wr(8'h39, 8'hC0);
        wr(8'h3A, 8'h00);
        wr(8'h56, 8'h04);
        chk("perf", {4'h0, ctrl_o.performance_setting}, 8'h0B);
        wr(8'h4F, 8'h01);
        chk("dc", {7'h0, ctrl_o.input_dc_coupling_enable}, 8'h01);
        wr(8'h4F, 8'h00);
        chk("dc", {7'h0, ctrl_o.input_dc_coupling_enable}, 8'h00);
        wr(8'h53, 8'h40);
        chk("sysref", {5'h0, ctrl_o.sysref_ignore,
            ctrl_o.sysref_high_common_mode_enable,
            ctrl_o.sysref_manual_level}, 8'h04);
        wr(8'h53, 8'h03);
        chk("sysref", {5'h0, ctrl_o.sysref_ignore,
            ctrl_o.sysref_high_common_mode_enable,
            ctrl_o.sysref_manual_level}, 8'h03);
        end_sim();
    end
    initial
    begin
        #100000;
        fails++;
        end_sim();
    end
endmodule : pdcr_bank_bench
